/* File: src/sis_cfg.svh */
`ifndef SIS_CFG_SVH
`define SIS_CFG_SVH
// clock rate and timing
`define SIS_CLK_MHZ    10
`define SIS_ARB_NS     2400
`define SIS_ARB_CYC    ((`SIS_ARB_NS * `SIS_CLK_MHZ + 999) / 1000)
`define SIS_TICK_US    1000
`define SIS_TICK_CYC   (`SIS_TICK_US * `SIS_CLK_MHZ)
// register byte offsets
`define SIS_OFS_STC    8'h00
`define SIS_OFS_CTC    8'h04
`define SIS_OFS_CMD    8'h0C
`define SIS_OFS_STAT   8'h10
`define SIS_OFS_IRQ    8'h14
`define SIS_OFS_STEP   8'h18
`define SIS_OFS_STIM   8'h1C
`define SIS_OFS_CTRL1  8'h20
`define SIS_OFS_TID    8'h24
// reset values
`define SIS_RST_STIM   8'hFF
`define SIS_RST_CTRL1  8'h07
// command codes, bit 7 of the written byte is the dma flag
`define SIS_DMA_BIT    7
`define SIS_C_NOP      7'h00
`define SIS_C_ITX      7'h10
`define SIS_C_CC       7'h11
`define SIS_C_MACC     7'h12
`define SIS_C_PAD      7'h18
`define SIS_C_SATN     7'h1A
`define SIS_C_RATN     7'h1B
`define SIS_C_SEL      7'h41
`define SIS_C_SATN1    7'h42
`define SIS_C_STOP     7'h43
`define SIS_C_ENSEL    7'h44
`define SIS_C_DISSEL   7'h45
`define SIS_C_SATN3    7'h46
// bus phases as {msg, cd, io}
`define SIS_PH_CMD     3'h2
`define SIS_PH_STAT    3'h3
`define SIS_PH_MSGO    3'h6
`define SIS_PH_MSGI    3'h7
`define SIS_PH_IO      0
// interrupt status bits
`define SIS_IRQ_W      6
`define SIS_I_SUCC     0
`define SIS_I_SVC      1
`define SIS_I_DISC     2
`define SIS_I_INV      3
`define SIS_I_SELD     4
`define SIS_I_TMO      5
// axi responses
`define SIS_RESP_OK    2'h0
`define SIS_RESP_DEC   2'h3
`endif

/* File: src/sis_pkg.sv */
`default_nettype none
package sis_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ARB, ST_SEL, ST_MSGO, ST_CMDP, ST_XFER,
		ST_CCST, ST_CCMS, ST_WREQ, ST_RESEL
	} sis_state_t;
	typedef enum logic [1:0] {SK_NOATN, SK_ATN1, SK_STOP, SK_ATN3} sis_kind_t;
	typedef enum logic [1:0] {HS_IDLE, HS_WREQ, HS_WNREQ, HS_HELD} sis_hs_t;
	typedef struct packed {
		logic       bsy;
		logic       sel;
		logic       req;
		logic [2:0] phase;
		logic [7:0] data;
	} sis_bus_in_t;
	typedef struct packed {
		logic       bsy;
		logic       sel;
		logic       atn;
		logic       ack;
		logic       data_oe;
		logic [7:0] data;
	} sis_bus_out_t;
endpackage
`default_nettype wire

/* File: src/sis_handshake.sv */
`default_nettype none
module sis_handshake
	import sis_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// control from the sequencer
	input  wire logic       start,
	input  wire logic       hold,
	input  wire logic       release_ack,
	input  wire logic       abort,
	// bus side
	input  wire logic       req,
	input  wire logic [7:0] bus_data,
	// results
	output logic            ack,
	output logic            done,
	output logic [7:0]      rx_byte
);
	sis_hs_t hs;

	// one req/ack byte; ack may be left high after the byte for the host to inspect
	always_ff @(posedge clk) begin
		if (srst || abort) begin
			hs <= HS_IDLE;
			ack <= 1'b0;
			done <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			done <= 1'b0;
			unique case (hs)
				HS_IDLE: if (start) hs <= HS_WREQ;
				HS_WREQ: if (req) begin
					rx_byte <= bus_data;
					ack <= 1'b1;
					hs <= HS_WNREQ;
				end
				HS_WNREQ: if (!req) begin
					done <= 1'b1;
					if (hold) begin
						hs <= HS_HELD;
					end else begin
						ack <= 1'b0;
						hs <= HS_IDLE;
					end
				end
				HS_HELD: if (release_ack) begin
					ack <= 1'b0;
					hs <= HS_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: src/sis_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`include "sis_cfg.svh"
`default_nettype none
module sis_top
	import sis_pkg::*;
#(
	parameter int unsigned TICK_CYC = `SIS_TICK_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// scsi bus
	input  wire sis_bus_in_t bus_in,
	output sis_bus_out_t     bus_out,
	// outgoing byte source
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	// received bytes
	output logic [7:0]       rx_data,
	output logic             rx_valid
);
	////////////////////////////////////////////////////////////////////////////
	sis_state_t             st;
	sis_kind_t              kind;
	logic [15:0]            start_count_reg;
	logic [15:0]            ctc;
	logic [7:0]             selection_timeout_reg;
	logic [7:0]             control_one_reg;
	logic [7:0]             target_id_reg;
	logic [7:0]             sequence_step_state;
	logic [`SIS_IRQ_W-1:0]  irq_stat;
	logic [`SIS_IRQ_W-1:0]  irq_set;
	logic [`SIS_IRQ_W-1:0]  irq_clr;
	logic [7:0]             q0;
	logic [7:0]             q1;
	logic [1:0]             q_cnt;
	logic                   q_push;
	logic                   cmd_take;
	logic                   cmd_bad;
	logic                   dma;
	logic                   pad;
	logic                   atn;
	logic                   connected;
	logic                   resel_en;
	logic                   byte_act;
	logic                   byte_out;
	logic                   hold_b;
	logic [1:0]             msg_left;
	logic [2:0]             xphase;
	logic [7:0]             arb_cnt;
	logic [31:0]            tick_div;
	logic [7:0]             tick_cnt;
	logic                   hs_go;
	logic                   hs_rel;
	logic                   hs_abort;
	logic                   hs_ack;
	logic                   hs_done;
	logic [7:0]             hs_rx;
	logic                   disc;
	logic                   sel_me;
	logic                   want;
	logic                   last_b;
	logic [6:0]             op;
	logic [31:0]            rd_mux;
	logic                   rd_hit;

	////////////////////////////////////////////////////////////////////////////
	// byte handshake engine shared by every phase
	sis_handshake u_hs (
		.clk         (clk),
		.srst        (srst),
		.start       (hs_go),
		.hold        (hold_b),
		.release_ack (hs_rel),
		.abort       (hs_abort),
		.req         (bus_in.req),
		.bus_data    (bus_in.data),
		.ack         (hs_ack),
		.done        (hs_done),
		.rx_byte     (hs_rx)
	);

	////////////////////////////////////////////////////////////////////////////
	// command decode and bus condition terms
	always_comb begin
		op = q0[6:0];
		disc = connected && !bus_in.bsy;
		sel_me = bus_in.sel && !bus_in.bsy && bus_in.data[control_one_reg[2:0]];
		want = bus_in.req && !byte_act;
		last_b = dma && (ctc == 16'h0001);
		cmd_take = (st == ST_IDLE) && (q_cnt != 2'h0) && !disc
			&& !(sel_me && resel_en && !connected);
		cmd_bad = 1'b1;
		if (op == `SIS_C_NOP) begin
			cmd_bad = 1'b0;
		end else if (op inside {`SIS_C_SEL, `SIS_C_SATN1, `SIS_C_STOP,
			`SIS_C_ENSEL, `SIS_C_DISSEL, `SIS_C_SATN3}) begin
			cmd_bad = connected;
		end else if (op inside {`SIS_C_ITX, `SIS_C_CC, `SIS_C_MACC,
			`SIS_C_PAD, `SIS_C_SATN, `SIS_C_RATN}) begin
			cmd_bad = !connected;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-entry command queue; held empty while being selected by the bus
	assign q_push = s_axi_awready && (s_axi_awaddr == `SIS_OFS_CMD) && s_axi_wstrb[0];
	always_ff @(posedge clk) begin
		if (srst || st == ST_RESEL || (cmd_take && cmd_bad)) begin
			q_cnt <= 2'h0;
			q0 <= 8'h00;
			q1 <= 8'h00;
		end else if (q_push && q_cnt != 2'h2 && !cmd_take) begin
			if (q_cnt == 2'h0)
				q0 <= s_axi_wdata[7:0];
			else
				q1 <= s_axi_wdata[7:0];
			q_cnt <= q_cnt + 2'h1;
		end else if (q_push && cmd_take) begin
			q0 <= (q_cnt == 2'h1) ? s_axi_wdata[7:0] : q1;
			q1 <= s_axi_wdata[7:0];
		end else if (cmd_take) begin
			q0 <= q1;
			q_cnt <= q_cnt - 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= ST_IDLE;
			kind <= SK_NOATN;
			ctc <= 16'h0000;
			sequence_step_state <= 8'h00;
			dma <= 1'b0;
			pad <= 1'b0;
			atn <= 1'b0;
			connected <= 1'b0;
			resel_en <= 1'b0;
			byte_act <= 1'b0;
			byte_out <= 1'b0;
			hold_b <= 1'b0;
			msg_left <= 2'h0;
			xphase <= 3'h0;
			arb_cnt <= 8'h00;
			tick_div <= 32'h0000_0000;
			tick_cnt <= 8'h00;
			hs_go <= 1'b0;
			hs_rel <= 1'b0;
			hs_abort <= 1'b0;
			irq_set <= '0;
			bus_out <= '0;
			tx_ready <= 1'b0;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			hs_go <= 1'b0;
			hs_rel <= 1'b0;
			hs_abort <= 1'b0;
			irq_set <= '0;
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			bus_out.ack <= hs_ack;
			bus_out.atn <= atn;
			// every finished byte: count it when dma is set and pass received data on
			if (hs_done) begin
				byte_act <= 1'b0;
				if (dma && ctc != 16'h0000)
					ctc <= ctc - 16'h0001;
				if (!byte_out) begin
					rx_data <= hs_rx;
					rx_valid <= 1'b1;
				end
			end
			// next byte is started only on req with the phase already checked
			if (disc) begin
				connected <= 1'b0;
				resel_en <= 1'b0;
				atn <= 1'b0;
				hs_abort <= 1'b1;
				byte_act <= 1'b0;
				bus_out.data_oe <= 1'b0;
				irq_set[`SIS_I_DISC] <= 1'b1;
				st <= ST_IDLE;
			end else begin
				unique case (st)
					ST_IDLE: begin
						if (sel_me && resel_en && !connected) begin
							bus_out.bsy <= 1'b1;
							st <= ST_RESEL;
						end else if (cmd_take && cmd_bad) begin
							irq_set[`SIS_I_INV] <= 1'b1;
						end else if (cmd_take) begin
							dma <= q0[`SIS_DMA_BIT];
							if (q0[`SIS_DMA_BIT])
								ctc <= start_count_reg;
							pad <= (op == `SIS_C_PAD);
							xphase <= bus_in.phase;
							unique case (op)
								`SIS_C_SEL: begin
									kind <= SK_NOATN;
									st <= ST_ARB;
								end
								`SIS_C_SATN1: begin
									kind <= SK_ATN1;
									msg_left <= 2'h1;
									st <= ST_ARB;
								end
								`SIS_C_STOP: begin
									kind <= SK_STOP;
									msg_left <= 2'h1;
									st <= ST_ARB;
								end
								`SIS_C_SATN3: begin
									kind <= SK_ATN3;
									msg_left <= 2'h3;
									st <= ST_ARB;
								end
								`SIS_C_ENSEL: resel_en <= 1'b1;
								`SIS_C_DISSEL: begin
									resel_en <= 1'b0;
									irq_set[`SIS_I_SUCC] <= 1'b1;
								end
								`SIS_C_ITX, `SIS_C_PAD: st <= ST_XFER;
								`SIS_C_CC: st <= ST_CCST;
								`SIS_C_MACC: begin
									hs_rel <= 1'b1;
									st <= ST_WREQ;
								end
								`SIS_C_SATN: atn <= 1'b1;
								`SIS_C_RATN: atn <= 1'b0;
								default: ;
							endcase
						end
					end
					// bus free, then own id for the arbitration delay
					ST_ARB: begin
						if (!bus_out.bsy) begin
							if (!bus_in.bsy && !bus_in.sel) begin
								bus_out.bsy <= 1'b1;
								bus_out.data_oe <= 1'b1;
								bus_out.data <= 8'h01 << control_one_reg[2:0];
								arb_cnt <= 8'h00;
								sequence_step_state <= 8'h00;        // selects only
							end
						end else if (arb_cnt != 8'(`SIS_ARB_CYC)) begin
							arb_cnt <= arb_cnt + 8'h01;
						end else begin
							bus_out.sel <= 1'b1;
							bus_out.data <= bus_out.data | (8'h01 << target_id_reg[2:0]);
							atn <= (kind != SK_NOATN);
							sequence_step_state <= 8'h01;
							tick_div <= 32'h0000_0000;
							tick_cnt <= 8'h00;
							st <= ST_SEL;
						end
					end
					// wait for the target's busy or time out
					ST_SEL: begin
						bus_out.bsy <= 1'b0;
						if (bus_in.bsy) begin
							bus_out.sel <= 1'b0;
							bus_out.data_oe <= 1'b0;
							connected <= 1'b1;
							sequence_step_state <= 8'h02;
							st <= (kind == SK_NOATN) ? ST_CMDP : ST_MSGO;
						end else if (tick_cnt == selection_timeout_reg) begin
							bus_out.sel <= 1'b0;
							bus_out.data_oe <= 1'b0;
							atn <= 1'b0;
							irq_set[`SIS_I_DISC] <= 1'b1;
							irq_set[`SIS_I_TMO] <= 1'b1;
							st <= ST_IDLE;
						end else if (tick_div == TICK_CYC - 1) begin
							tick_div <= 32'h0000_0000;
							tick_cnt <= tick_cnt + 8'h01;
						end else begin
							tick_div <= tick_div + 32'h0000_0001;
						end
					end
					// identify and further message bytes; atn drops for the last one unless stopping
					ST_MSGO: begin
						if (hs_done && msg_left == 2'h1) begin
							sequence_step_state <= 8'h03;
							if (kind == SK_STOP) begin
								irq_set[`SIS_I_SUCC] <= 1'b1;
								st <= ST_IDLE;
							end else begin
								st <= ST_CMDP;
							end
						end else if (hs_done) begin
							msg_left <= msg_left - 2'h1;
						end else if (want && bus_in.phase != `SIS_PH_MSGO) begin
							irq_set[`SIS_I_SVC] <= 1'b1;
							bus_out.data_oe <= 1'b0;
							st <= ST_IDLE;
						end else if (want && tx_valid) begin
							if (msg_left == 2'h1 && kind != SK_STOP)
								atn <= 1'b0;
							byte_act <= 1'b1;
							byte_out <= 1'b1;
							hold_b <= 1'b0;
							hs_go <= 1'b1;
							tx_ready <= 1'b1;
							bus_out.data_oe <= 1'b1;
							bus_out.data <= tx_data;
						end
					end
					// command descriptor block until the target leaves the phase
					ST_CMDP: begin
						if (want && bus_in.phase != `SIS_PH_CMD) begin
							bus_out.data_oe <= 1'b0;
							st <= ST_IDLE;
							if (sequence_step_state == 8'h04 && (!dma || ctc == 16'h0000)) begin
								irq_set[`SIS_I_SUCC] <= 1'b1;
								irq_set[`SIS_I_SVC] <= (kind != SK_NOATN);
							end else begin
								irq_set[`SIS_I_SVC] <= 1'b1;
							end
						end else if (want && tx_valid && !(dma && ctc == 16'h0000)) begin
							sequence_step_state <= 8'h04;
							byte_act <= 1'b1;
							byte_out <= 1'b1;
							hold_b <= 1'b0;
							hs_go <= 1'b1;
							tx_ready <= 1'b1;
							bus_out.data_oe <= 1'b1;
							bus_out.data <= tx_data;
						end
					end
					// information transfer or null padding, ended by the count
					ST_XFER: begin
						if (hs_done && dma && ctc == 16'h0001) begin
							if (hold_b) begin
								irq_set[`SIS_I_SUCC] <= 1'b1;
								st <= ST_IDLE;
							end else begin
								st <= ST_WREQ;
							end
						end else if (want && (bus_in.phase != xphase || !dma)) begin
							irq_set[`SIS_I_SVC] <= 1'b1;
							bus_out.data_oe <= 1'b0;
							st <= ST_IDLE;
						end else if (want && (pad || tx_valid || xphase[`SIS_PH_IO])) begin
							if (last_b && xphase == `SIS_PH_MSGO)
								atn <= 1'b0;
							byte_act <= 1'b1;
							byte_out <= !xphase[`SIS_PH_IO];
							hold_b <= last_b && !pad && xphase == `SIS_PH_MSGI;
							hs_go <= 1'b1;
							tx_ready <= !pad && !xphase[`SIS_PH_IO];
							bus_out.data_oe <= !xphase[`SIS_PH_IO];
							bus_out.data <= pad ? 8'h00 : tx_data;
						end
					end
					// completion steps: status byte, then message byte kept
					ST_CCST: begin
						if (hs_done) begin
							st <= ST_CCMS;
						end else if (want && bus_in.phase != `SIS_PH_STAT) begin
							irq_set[`SIS_I_SVC] <= 1'b1;
							st <= ST_IDLE;
						end else if (want) begin
							byte_act <= 1'b1;
							byte_out <= 1'b0;
							hold_b <= 1'b0;
							hs_go <= 1'b1;
							bus_out.data_oe <= 1'b0;
						end
					end
					ST_CCMS: begin
						if (hs_done) begin
							irq_set[`SIS_I_SUCC] <= 1'b1;
							st <= ST_IDLE;
						end else if (want && bus_in.phase != `SIS_PH_MSGI) begin
							irq_set[`SIS_I_SVC] <= 1'b1;
							st <= ST_IDLE;
						end else if (want) begin
							byte_act <= 1'b1;
							byte_out <= 1'b0;
							hold_b <= 1'b1;
							hs_go <= 1'b1;
						end
					end
					// ack released: report once the target asks again
					ST_WREQ: begin
						if (bus_in.req && !hs_ack) begin
							irq_set[`SIS_I_SVC] <= 1'b1;
							bus_out.data_oe <= 1'b0;
							st <= ST_IDLE;
						end
					end
					// answering a bus-initiated selection
					ST_RESEL: begin
						if (!bus_in.sel) begin
							bus_out.bsy <= 1'b0;
							connected <= 1'b1;
							irq_set[`SIS_I_SELD] <= 1'b1;
							st <= ST_IDLE;
						end
					end
					default: st <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear; a new event beats the clear
	assign irq_clr = (s_axi_awready && s_axi_awaddr == `SIS_OFS_IRQ && s_axi_wstrb[0])
		? s_axi_wdata[`SIS_IRQ_W-1:0] : '0;
	always_ff @(posedge clk) begin
		if (srst)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end

	////////////////////////////////////////////////////////////////////////////
	// axi write: address and data taken together, response the cycle after
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SIS_RESP_OK;
			start_count_reg <= 16'h0000;
			selection_timeout_reg <= `SIS_RST_STIM;
			control_one_reg <= `SIS_RST_CTRL1;
			target_id_reg <= 8'h00;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `SIS_RESP_OK;
				unique case (s_axi_awaddr)
					`SIS_OFS_STC: begin
						if (s_axi_wstrb[0])
							start_count_reg[7:0] <= s_axi_wdata[7:0];
						if (s_axi_wstrb[1])
							start_count_reg[15:8] <= s_axi_wdata[15:8];
					end
					`SIS_OFS_STIM: if (s_axi_wstrb[0]) selection_timeout_reg <= s_axi_wdata[7:0];
					`SIS_OFS_CTRL1: if (s_axi_wstrb[0]) control_one_reg <= s_axi_wdata[7:0];
					`SIS_OFS_TID: if (s_axi_wstrb[0]) target_id_reg <= s_axi_wdata[7:0];
					`SIS_OFS_CTC, `SIS_OFS_CMD, `SIS_OFS_STAT, `SIS_OFS_IRQ,
					`SIS_OFS_STEP: ;
					default: s_axi_bresp <= `SIS_RESP_DEC;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi read
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`SIS_OFS_STC: rd_mux[15:0] = start_count_reg;
			`SIS_OFS_CTC: rd_mux[15:0] = ctc;
			`SIS_OFS_CMD: rd_mux[7:0] = q0;
			`SIS_OFS_STAT: rd_mux[7:0] = {resel_en, connected, atn, bus_in.req, 1'b0,
				bus_in.phase};
			`SIS_OFS_IRQ: rd_mux[`SIS_IRQ_W-1:0] = irq_stat;
			`SIS_OFS_STEP: rd_mux[7:0] = sequence_step_state;
			`SIS_OFS_STIM: rd_mux[7:0] = selection_timeout_reg;
			`SIS_OFS_CTRL1: rd_mux[7:0] = control_one_reg;
			`SIS_OFS_TID: rd_mux[7:0] = target_id_reg;
			default: rd_hit = 1'b0;
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SIS_RESP_OK;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid)
				s_axi_arready <= 1'b1;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `SIS_RESP_OK : `SIS_RESP_DEC;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/sis_asserts.sv */
`include "sis_cfg.svh"
`default_nettype none
module sis_asserts
	import sis_pkg::*;
(
	// clock and reset
	input wire logic         clk,
	input wire logic         srst,
	// axi handshakes
	input wire logic         s_axi_awready,
	input wire logic         s_axi_wready,
	input wire logic [1:0]   s_axi_bresp,
	input wire logic         s_axi_bvalid,
	input wire logic         s_axi_bready,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	// bus and streams
	input wire sis_bus_in_t  bus_in,
	input wire sis_bus_out_t bus_out,
	input wire logic         tx_valid,
	input wire logic         tx_ready,
	input wire logic         rx_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// atn must be gone two cycles before the last message-out ack
	sequence s_atn_drop;
		$fell(bus_out.atn) && bus_in.req && bus_in.phase == `SIS_PH_MSGO;
	endsequence
	sequence s_ack_up;
		##2 $rose(bus_out.ack);
	endsequence
	AST_ATN_LAST: assert property (s_atn_drop |-> s_ack_up)
		else $error("ack did not follow atn drop");
	AST_ACK_LAT: assert property ($rose(bus_out.ack) |-> $past(bus_in.req, 2))
		else $error("ack rose without req");
	AST_ACK_HOLD: assert property (bus_out.ack && bus_in.req && bus_in.bsy |=> bus_out.ack)
		else $error("ack dropped while req high");
	AST_AW_PAIR: assert property (s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid)
		else $error("write accept not paired");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	AST_TX_TAKE: assert property (tx_ready |-> tx_valid ##1 !tx_ready)
		else $error("byte taken without valid");
	AST_RX_PULSE: assert property (rx_valid |=> !rx_valid)
		else $error("rx valid longer than a cycle");
endmodule
bind sis_top sis_asserts i_sis_asserts (.*);
`default_nettype wire

/* File: tb/sis_target.sv */
`default_nettype none
module sis_target
	import sis_pkg::*;
(
	// bench control and bus
	input  wire logic         clk,
	input  wire logic         respond,
	input  wire sis_bus_out_t bo,
	output sis_bus_in_t       bi
);
	initial bi = '0;
	// answer selection with busy; dropping respond disconnects
	always @(posedge clk) begin
		if (bo.sel && respond)
			bi.bsy <= 1'b1;
		else if (!respond)
			bi.bsy <= 1'b0;
	end
	// one req/ack byte; released data is inverted so it never looks valid
	task automatic byte_req(input logic [2:0] p, input logic [7:0] d);
		int n;
		@(posedge clk);
		bi.phase <= p;
		bi.data <= d;
		bi.req <= 1'b1;
		for (n = 0; n < 60 && !bo.ack; n++)
			@(posedge clk);
		bi.req <= 1'b0;
		bi.data <= ~d;
		for (n = 0; n < 60 && bo.ack; n++)
			@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: tb/test_sis_top.sv */
`include "sis_cfg.svh"
`default_nettype none
module test_sis_top
	import sis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         clk = 1'b0, srst = 1'b1, respond = 1'b0, tx_valid = 1'b1;
	logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_data = 8'ha5, rx_data;
	logic [31:0]  s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]   s_axi_wstrb = 4'hf;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic         s_axi_rvalid, tx_ready, rx_valid;
	logic [1:0]   s_axi_bresp, s_axi_rresp;
	sis_bus_in_t  bus_in;
	sis_bus_out_t bus_out;
	int           miscompares = 0, tests_run = 0;
	sis_top #(.TICK_CYC(4)) i_sis_top (.*);
	sis_target i_sis_target (.clk(clk), .respond(respond), .bo(bus_out), .bi(bus_in));
	always #50 clk = ~clk;
	////////////////////////////////
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (!s_axi_awready);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// read one register and compare data and response
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#1000000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rc(`SIS_OFS_STIM, 32'h0000_00ff, 2'h0);
		rc(`SIS_OFS_CTRL1, 32'h0000_0007, 2'h0);
		rc(8'h3c, 32'h0000_0000, 2'h3);
		// select with atn: one message byte, one cdb byte, then status
		respond <= 1'b1;
		wr(`SIS_OFS_TID, 32'h0000_0003);
		wr(`SIS_OFS_CMD, `SIS_C_SATN1);
		@(posedge clk iff bus_out.sel);
		// atn leaves through one more register stage than sel
		@(posedge clk);
		chk("atn", bus_out.atn, 1'b1);
		i_sis_target.byte_req(`SIS_PH_MSGO, 8'h80);
		i_sis_target.byte_req(`SIS_PH_CMD, 8'h00);
		i_sis_target.byte_req(`SIS_PH_STAT, 8'h00);
		rc(`SIS_OFS_IRQ, 32'h0000_0003, 2'h0);
		// completion steps leave ack up; then set atn, accept, reset atn
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_CMD, `SIS_C_CC);
		i_sis_target.byte_req(`SIS_PH_STAT, 8'h00);
		i_sis_target.byte_req(`SIS_PH_MSGI, 8'h07);
		chk("ack", bus_out.ack, 1'b1);
		rc(`SIS_OFS_STEP, 32'h0000_0004, 2'h0);
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_CMD, `SIS_C_SATN);
		rc(`SIS_OFS_IRQ, 32'h0000_0000, 2'h0);
		chk("atn", bus_out.atn, 1'b1);
		wr(`SIS_OFS_CMD, `SIS_C_MACC);
		// take, release in the engine, then the output register
		repeat (3) @(posedge clk);
		chk("ack", bus_out.ack, 1'b0);
		i_sis_target.byte_req(`SIS_PH_MSGO, 8'h00);
		rc(`SIS_OFS_IRQ, 32'h0000_0002, 2'h0);
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_CMD, `SIS_C_RATN);
		rc(`SIS_OFS_IRQ, 32'h0000_0000, 2'h0);
		chk("atn", bus_out.atn, 1'b0);
		// idle command while connected is refused
		wr(`SIS_OFS_CMD, `SIS_C_ENSEL);
		rc(`SIS_OFS_IRQ, 32'h0000_0008, 2'h0);
		// target drops off, then a select times out
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		respond <= 1'b0;
		repeat (6) @(posedge clk);
		rc(`SIS_OFS_IRQ, 32'h0000_0004, 2'h0);
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_STIM, 32'h0000_0002);
		wr(`SIS_OFS_CMD, `SIS_C_SEL);
		repeat (100) @(posedge clk);
		rc(`SIS_OFS_IRQ, 32'h0000_0024, 2'h0);
		// enable then disable the selection response while disconnected
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_CMD, `SIS_C_ENSEL);
		rc(`SIS_OFS_STAT, 32'h0000_0086, 2'h0);
		wr(`SIS_OFS_CMD, `SIS_C_DISSEL);
		rc(`SIS_OFS_IRQ, 32'h0000_0001, 2'h0);
		rc(`SIS_OFS_STAT, 32'h0000_0006, 2'h0);
		// stop after the first message byte, then two more by transfer
		respond <= 1'b1;
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_CMD, `SIS_C_STOP);
		@(posedge clk iff bus_out.sel);
		i_sis_target.byte_req(`SIS_PH_MSGO, 8'h80);
		rc(`SIS_OFS_IRQ, 32'h0000_0001, 2'h0);
		chk("atn", bus_out.atn, 1'b1);
		wr(`SIS_OFS_IRQ, 32'h0000_003f);
		wr(`SIS_OFS_STC, 32'h0000_0002);
		wr(`SIS_OFS_CMD, {1'b1, `SIS_C_ITX});
		i_sis_target.byte_req(`SIS_PH_MSGO, 8'h01);
		chk("atn", bus_out.atn, 1'b1);
		i_sis_target.byte_req(`SIS_PH_MSGO, 8'h02);
		chk("atn", bus_out.atn, 1'b0);
		i_sis_target.byte_req(`SIS_PH_CMD, 8'h00);
		rc(`SIS_OFS_IRQ, 32'h0000_0002, 2'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
